/* eeq_pkg.sv */
// Package for the error event queue: constants, codes, strings and carriers
`default_nettype none
package eeq_pkg;

  // ----------------------------------------------------------------------
  // Queue geometry
  // ----------------------------------------------------------------------
  localparam int unsigned QUEUE_DEPTH  = 30;
  localparam int unsigned QUEUE_USABLE = 29;
  localparam int unsigned PTR_W        = 5;
  localparam int unsigned CODE_W       = 16;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 8;
  localparam logic [PTR_W-1:0] PTR_LAST   = 5'h1D;
  localparam logic [PTR_W-1:0] CNT_USABLE = 5'h1D;
  localparam logic [PTR_W-1:0] CNT_FULL   = 5'h1E;

  // ----------------------------------------------------------------------
  // Error codes (two's complement, 16 bits)
  // ----------------------------------------------------------------------
  localparam logic signed [CODE_W-1:0] CODE_NONE     = 16'sh0000;
  localparam logic signed [CODE_W-1:0] CODE_OVERFLOW = 16'shFEA2;
  localparam logic signed [CODE_W-1:0] CODE_SYNTAX   = 16'shFF9A;
  localparam logic signed [CODE_W-1:0] CODE_GET      = 16'shFF97;
  localparam logic signed [CODE_W-1:0] CODE_UNDEF    = 16'shFF8F;
  localparam logic signed [CODE_W-1:0] CODE_EXEC     = 16'shFF38;
  localparam logic signed [CODE_W-1:0] CODE_SELFTEST = 16'shFEB6;
  // Class bounds: upper end (least magnitude) and lower end of each range
  localparam logic signed [CODE_W-1:0] CMD_HI   = 16'shFF9C;
  localparam logic signed [CODE_W-1:0] CMD_LO   = 16'shFF39;
  localparam logic signed [CODE_W-1:0] EXEC_HI  = 16'shFF38;
  localparam logic signed [CODE_W-1:0] EXEC_LO  = 16'shFED5;
  localparam logic signed [CODE_W-1:0] DEV_HI   = 16'shFED4;
  localparam logic signed [CODE_W-1:0] DEV_LO   = 16'shFE71;
  localparam logic signed [CODE_W-1:0] QUERY_HI = 16'shFE70;
  localparam logic signed [CODE_W-1:0] QUERY_LO = 16'shFE0D;

  // ----------------------------------------------------------------------
  // Event status bits and register map
  // ----------------------------------------------------------------------
  localparam int unsigned ESR_W         = 8;
  localparam int unsigned ESR_QUERY_BIT = 2;
  localparam int unsigned ESR_DEV_BIT   = 3;
  localparam int unsigned ESR_EXEC_BIT  = 4;
  localparam int unsigned ESR_CMD_BIT   = 5;
  localparam logic [ADDR_W-1:0] REG_ERRQ   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ESR    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CLS    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_RESP   = 8'h10;
  localparam logic [ADDR_W-1:0] REG_DISP   = 8'h14;
  localparam int unsigned ERRQ_CLASS_LSB  = 16;
  localparam int unsigned STAT_EMPTY_BIT  = 5;
  localparam int unsigned STAT_OVF_BIT    = 6;
  localparam int unsigned RESP_VALID_BIT  = 8;
  localparam int unsigned DISP_VALID_BIT  = 16;

  // ----------------------------------------------------------------------
  // Response characters and description strings
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [2:0] DIG_LAST = 3'h4;
  localparam int unsigned STR_BYTES = 22;
  localparam int unsigned STR_W     = 8 * STR_BYTES;
  localparam logic [STR_W-1:0] TXT_NONE  = "No error";
  localparam logic [STR_W-1:0] TXT_CMD   = "Command error";
  localparam logic [STR_W-1:0] TXT_EXEC  = "Execution error";
  localparam logic [STR_W-1:0] TXT_DEV   = "Device-specific error";
  localparam logic [STR_W-1:0] TXT_QUERY = "Query error";
  localparam logic [STR_W-1:0] TXT_OVF   = "Queue overflow";
  localparam logic [STR_W-1:0] TXT_INSTR = "Instrument error";

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_NONE, CLS_CMD, CLS_EXEC, CLS_DEV, CLS_QUERY, CLS_INSTR, CLS_OVF
  } eeq_class_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } eeq_bus_req_type;

  typedef struct packed {
    logic                     codeValid;
    logic signed [CODE_W-1:0] code;
    logic                     syntaxErr;
    logic                     badHeader;
    logic                     getInMsg;
    logic                     rangeErr;
    logic                     paramRounded;
    logic                     execFail;
    logic                     selfTestFail;
  } eeq_event_type;

endpackage : eeq_pkg

`default_nettype wire

/* error_event_queue.sv */
// Error event queue: classification, 30-entry queue, query formatter
`timescale 1ns/1ps
`default_nettype none

module error_event_queue (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire eeq_pkg::eeq_bus_req_type      busReq,
  output logic [eeq_pkg::DATA_W-1:0]         busRdata,
  input  wire eeq_pkg::eeq_event_type        errEvent,
  input  wire logic                          measResultValid,
  output logic [eeq_pkg::ESR_W-1:0]          esrEvents,
  output logic signed [eeq_pkg::CODE_W-1:0]  dispCode,
  output logic                               dispShowErr
);
  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Range classification of a code
  function automatic eeq_pkg::eeq_class_type classOf(
    input logic signed [eeq_pkg::CODE_W-1:0] c);
    eeq_pkg::eeq_class_type k;
    k = eeq_pkg::CLS_NONE;
    if (c == eeq_pkg::CODE_OVERFLOW)
      k = eeq_pkg::CLS_OVF;
    else if (c <= eeq_pkg::CMD_HI && c >= eeq_pkg::CMD_LO)
      k = eeq_pkg::CLS_CMD;
    else if (c <= eeq_pkg::EXEC_HI && c >= eeq_pkg::EXEC_LO)
      k = eeq_pkg::CLS_EXEC;
    else if (c <= eeq_pkg::DEV_HI && c >= eeq_pkg::DEV_LO)
      k = eeq_pkg::CLS_DEV;
    else if (c <= eeq_pkg::QUERY_HI && c >= eeq_pkg::QUERY_LO)
      k = eeq_pkg::CLS_QUERY;
    else if (c > eeq_pkg::CODE_NONE)
      k = eeq_pkg::CLS_INSTR;
    return k;
  endfunction : classOf
  // Description text of a class
  function automatic logic [eeq_pkg::STR_W-1:0] textOf(
    input eeq_pkg::eeq_class_type k);
    logic [eeq_pkg::STR_W-1:0] t;
    t = eeq_pkg::TXT_NONE;
    unique case (k)
      eeq_pkg::CLS_NONE:  t = eeq_pkg::TXT_NONE;
      eeq_pkg::CLS_CMD:   t = eeq_pkg::TXT_CMD;
      eeq_pkg::CLS_EXEC:  t = eeq_pkg::TXT_EXEC;
      eeq_pkg::CLS_DEV:   t = eeq_pkg::TXT_DEV;
      eeq_pkg::CLS_QUERY: t = eeq_pkg::TXT_QUERY;
      eeq_pkg::CLS_INSTR: t = eeq_pkg::TXT_INSTR;
      eeq_pkg::CLS_OVF:   t = eeq_pkg::TXT_OVF;
      default:            t = eeq_pkg::TXT_NONE;
    endcase
    return t;
  endfunction : textOf
  // Index of first non-zero byte; strings sit right-justified
  function automatic logic [4:0] textStart(
    input logic [eeq_pkg::STR_W-1:0] t);
    logic [4:0] s;
    logic       found;
    s = 5'h00;
    found = 1'b0;
    for (int i = 0; i < eeq_pkg::STR_BYTES; i++) begin
      if (!found && t[eeq_pkg::STR_W-1-8*i -: 8] == 8'h00)
        s = 5'(i + 1);
      else
        found = 1'b1;
    end
    return s;
  endfunction : textStart
  // One decimal digit of a magnitude, position 0 is ten thousands
  function automatic logic [3:0] digitOf(input logic [15:0] m,
                                         input logic [2:0]  p);
    logic [15:0] d;
    d = 16'h0000;
    unique case (p)
      3'h0:    d = m / 16'h2710;
      3'h1:    d = (m / 16'h03E8) % 16'h000A;
      3'h2:    d = (m / 16'h0064) % 16'h000A;
      3'h3:    d = (m / 16'h000A) % 16'h000A;
      default: d = m % 16'h000A;
    endcase
    return d[3:0];
  endfunction : digitOf
  // ----------------------------------------------------------------------
  // Event selection and classification
  // ----------------------------------------------------------------------
  logic                             evtValid;
  logic signed [eeq_pkg::CODE_W-1:0] evtCode;
  eeq_pkg::eeq_class_type           evtClass;
  // Command events outrank execution ones so one event is one class only
  always_comb begin
    evtValid = 1'b1;
    evtCode  = eeq_pkg::CODE_NONE;
    if (errEvent.codeValid)
      evtCode = errEvent.code;
    else if (errEvent.syntaxErr)
      evtCode = eeq_pkg::CODE_SYNTAX;
    else if (errEvent.badHeader)
      evtCode = eeq_pkg::CODE_UNDEF;
    else if (errEvent.getInMsg)
      evtCode = eeq_pkg::CODE_GET;
    else if (errEvent.rangeErr && errEvent.paramRounded)
      evtCode = eeq_pkg::CODE_EXEC;
    else if (errEvent.execFail)
      evtCode = eeq_pkg::CODE_EXEC;
    else if (errEvent.selfTestFail)
      evtCode = eeq_pkg::CODE_SELFTEST;
    else
      evtValid = 1'b0;
    if (evtCode == eeq_pkg::CODE_NONE)
      evtValid = 1'b0;
  end

  assign evtClass = classOf(evtCode);
  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic queryPop;
  logic clsCmd;
  logic esrWrite;
  logic respRead;
  assign queryPop = busReq.rd && busReq.addr == eeq_pkg::REG_ERRQ;
  assign respRead = busReq.rd && busReq.addr == eeq_pkg::REG_RESP;
  assign clsCmd   = busReq.wr && busReq.addr == eeq_pkg::REG_CLS;
  assign esrWrite = busReq.wr && busReq.addr == eeq_pkg::REG_ESR;
  // ----------------------------------------------------------------------
  // Queue storage and pointers
  // ----------------------------------------------------------------------
  logic signed [eeq_pkg::CODE_W-1:0] queueMem [eeq_pkg::QUEUE_DEPTH];
  logic [eeq_pkg::PTR_W-1:0] head_ff;
  logic [eeq_pkg::PTR_W-1:0] tail_ff;
  logic [eeq_pkg::PTR_W-1:0] count_ff;
  logic [eeq_pkg::PTR_W-1:0] countAfterPop;
  logic [eeq_pkg::PTR_W-1:0] nxt_count;
  logic                      popDone;
  logic                      pushOrdinary;
  logic                      pushMarker;
  logic                      pushAny;
  logic signed [eeq_pkg::CODE_W-1:0] headCode;
  logic signed [eeq_pkg::CODE_W-1:0] pushCode;

  assign popDone  = queryPop && count_ff != '0;
  assign headCode = popDone ? queueMem[head_ff] : eeq_pkg::CODE_NONE;
  // Pop is applied before a same-cycle push
  assign countAfterPop = popDone ? count_ff - 5'h01 : count_ff;
  assign pushOrdinary  = evtValid && !clsCmd &&
                         countAfterPop < eeq_pkg::CNT_USABLE;
  assign pushMarker    = evtValid && !clsCmd &&
                         countAfterPop == eeq_pkg::CNT_USABLE;
  assign pushAny  = pushOrdinary || pushMarker;
  assign pushCode = pushMarker ? eeq_pkg::CODE_OVERFLOW : evtCode;
  assign nxt_count = countAfterPop + (pushAny ? 5'h01 : 5'h00);
  // Pointers wrap at thirty; clear-status drops everything at once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      head_ff  <= '0;
      tail_ff  <= '0;
      count_ff <= '0;
    end else if (clsCmd) begin
      head_ff  <= '0;
      tail_ff  <= '0;
      count_ff <= '0;
    end else begin
      if (popDone)
        head_ff <= (head_ff == eeq_pkg::PTR_LAST) ? '0 : head_ff + 5'h01;
      if (pushAny)
        tail_ff <= (tail_ff == eeq_pkg::PTR_LAST) ? '0 : tail_ff + 5'h01;
      count_ff <= nxt_count;
    end
  end

  // Tail write; storage has no reset since pointers guard it
  always_ff @(posedge mclk) begin
    if (pushAny)
      queueMem[tail_ff] <= pushCode;
  end

  // ----------------------------------------------------------------------
  // Event status bits
  // ----------------------------------------------------------------------
  logic [eeq_pkg::ESR_W-1:0] esr_ff;
  logic [eeq_pkg::ESR_W-1:0] esrSet;
  logic                      evtTaken;
  // Dropped errors still count as events: full queue is no excuse
  assign evtTaken = evtValid && !clsCmd;
  always_comb begin
    esrSet = '0;
    if (evtTaken) begin
      unique case (evtClass)
        eeq_pkg::CLS_CMD:   esrSet[eeq_pkg::ESR_CMD_BIT]   = 1'b1;
        eeq_pkg::CLS_EXEC:  esrSet[eeq_pkg::ESR_EXEC_BIT]  = 1'b1;
        eeq_pkg::CLS_DEV,
        eeq_pkg::CLS_INSTR,
        eeq_pkg::CLS_OVF:   esrSet[eeq_pkg::ESR_DEV_BIT]   = 1'b1;
        eeq_pkg::CLS_QUERY: esrSet[eeq_pkg::ESR_QUERY_BIT] = 1'b1;
        default:            esrSet = '0;
      endcase
    end
    if (pushMarker)
      esrSet[eeq_pkg::ESR_DEV_BIT] = 1'b1;
  end

  // Write one to clear; a same-cycle set wins over the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      esr_ff <= '0;
    else if (clsCmd)
      esr_ff <= '0;
    else if (esrWrite)
      esr_ff <= (esr_ff & ~busReq.wdata[eeq_pkg::ESR_W-1:0]) | esrSet;
    else
      esr_ff <= esr_ff | esrSet;
  end

  assign esrEvents = esr_ff;
  // ----------------------------------------------------------------------
  // Front display of the last detected error
  // ----------------------------------------------------------------------
  logic signed [eeq_pkg::CODE_W-1:0] dispCode_ff;
  logic                              dispShow_ff;

  // A new error wins over a measurement result in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dispCode_ff <= eeq_pkg::CODE_NONE;
      dispShow_ff <= 1'b0;
    end else if (evtValid) begin
      dispCode_ff <= evtCode;
      dispShow_ff <= 1'b1;
    end else if (measResultValid) begin
      dispShow_ff <= 1'b0;
    end
  end

  assign dispCode    = dispCode_ff;
  assign dispShowErr = dispShow_ff;
  // ----------------------------------------------------------------------
  // Response formatter: sign, digits, comma, quoted text
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_IDLE, FMT_SIGN, FMT_DIGIT, FMT_COMMA, FMT_OPENQ, FMT_TEXT, FMT_CLOSEQ
  } eeq_fmt_type;

  eeq_fmt_type                 fmtState_ff;
  logic [15:0]                 fmtMag_ff;
  logic                        fmtNeg_ff;
  logic [2:0]                  fmtDig_ff;
  logic [4:0]                  fmtIdx_ff;
  logic [eeq_pkg::STR_W-1:0]   fmtText_ff;
  logic [15:0]                 popMag;
  logic [2:0]                  popFirstDig;
  logic [7:0]                  fmtChar;
  logic [eeq_pkg::STR_W-1:0]   popText;

  // Magnitude and leading-zero suppression of the popped code
  assign popMag = headCode[eeq_pkg::CODE_W-1] ? 16'(-headCode)
                                              : 16'(headCode);
  assign popText = textOf(classOf(headCode));
  always_comb begin
    if (popMag >= 16'h2710)      popFirstDig = 3'h0;
    else if (popMag >= 16'h03E8) popFirstDig = 3'h1;
    else if (popMag >= 16'h0064) popFirstDig = 3'h2;
    else if (popMag >= 16'h000A) popFirstDig = 3'h3;
    else                         popFirstDig = eeq_pkg::DIG_LAST;
  end

  // Character at the current formatter position
  always_comb begin
    fmtChar = 8'h00;
    unique case (fmtState_ff)
      FMT_IDLE:   fmtChar = 8'h00;
      FMT_SIGN:   fmtChar = fmtNeg_ff ? eeq_pkg::CH_MINUS
                                      : eeq_pkg::CH_PLUS;
      FMT_DIGIT:  fmtChar = eeq_pkg::CH_ZERO +
                            {4'h0, digitOf(fmtMag_ff, fmtDig_ff)};
      FMT_COMMA:  fmtChar = eeq_pkg::CH_COMMA;
      FMT_OPENQ,
      FMT_CLOSEQ: fmtChar = eeq_pkg::CH_QUOTE;
      FMT_TEXT:   fmtChar = fmtText_ff[eeq_pkg::STR_W-1-8*fmtIdx_ff -: 8];
    endcase
  end

  // Every query reloads the formatter; each character read advances it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fmtState_ff <= FMT_IDLE;
      fmtMag_ff   <= '0;
      fmtNeg_ff   <= 1'b0;
      fmtDig_ff   <= '0;
      fmtIdx_ff   <= '0;
      fmtText_ff  <= '0;
    end else if (queryPop) begin
      fmtState_ff <= FMT_SIGN;
      fmtMag_ff   <= popMag;
      fmtNeg_ff   <= headCode[eeq_pkg::CODE_W-1];
      fmtDig_ff   <= popFirstDig;
      fmtIdx_ff   <= textStart(popText);
      fmtText_ff  <= popText;
    end else if (respRead) begin
      unique case (fmtState_ff)
        FMT_IDLE:   fmtState_ff <= FMT_IDLE;
        FMT_SIGN:   fmtState_ff <= FMT_DIGIT;
        FMT_DIGIT: begin
          if (fmtDig_ff == eeq_pkg::DIG_LAST)
            fmtState_ff <= FMT_COMMA;
          else
            fmtDig_ff <= fmtDig_ff + 3'h1;
        end
        FMT_COMMA:  fmtState_ff <= FMT_OPENQ;
        FMT_OPENQ:  fmtState_ff <= FMT_TEXT;
        FMT_TEXT: begin
          if (fmtIdx_ff == 5'(eeq_pkg::STR_BYTES - 1))
            fmtState_ff <= FMT_CLOSEQ;
          else
            fmtIdx_ff <= fmtIdx_ff + 5'h01;
        end
        FMT_CLOSEQ: fmtState_ff <= FMT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  logic [eeq_pkg::DATA_W-1:0] rdData_ff;
  logic [eeq_pkg::DATA_W-1:0] nxt_rdData;

  // Unmapped addresses read as zero
  always_comb begin
    nxt_rdData = '0;
    if (busReq.rd) begin
      unique case (busReq.addr)
        eeq_pkg::REG_ERRQ: begin
          nxt_rdData[eeq_pkg::CODE_W-1:0] = headCode;
          nxt_rdData[eeq_pkg::ERRQ_CLASS_LSB +: 3] = classOf(headCode);
        end
        eeq_pkg::REG_STATUS: begin
          nxt_rdData[eeq_pkg::PTR_W-1:0] = count_ff;
          nxt_rdData[eeq_pkg::STAT_EMPTY_BIT] = count_ff == '0;
          nxt_rdData[eeq_pkg::STAT_OVF_BIT] = count_ff == eeq_pkg::CNT_FULL;
        end
        eeq_pkg::REG_ESR:
          nxt_rdData[eeq_pkg::ESR_W-1:0] = esr_ff;
        eeq_pkg::REG_RESP: begin
          nxt_rdData[7:0] = fmtChar;
          nxt_rdData[eeq_pkg::RESP_VALID_BIT] = fmtState_ff != FMT_IDLE;
        end
        eeq_pkg::REG_DISP: begin
          nxt_rdData[eeq_pkg::CODE_W-1:0] = dispCode_ff;
          nxt_rdData[eeq_pkg::DISP_VALID_BIT] = dispShow_ff;
        end
        default: nxt_rdData = '0;
      endcase
    end
  end

  // Data stands for the single cycle after the read strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rdData_ff <= '0;
    else
      rdData_ff <= nxt_rdData;
  end

  assign busRdata = rdData_ff;
endmodule : error_event_queue

`default_nettype wire

/* eeq_properties.sv */
// Checker of event status, read data and display timing at the ports
`timescale 1ns/1ps
`default_nettype none
module eeq_checker (
  input wire logic                     mclk,
  input wire logic                     nrst,
  input wire eeq_pkg::eeq_bus_req_type busReq,
  input wire logic [31:0]              busRdata,
  input wire eeq_pkg::eeq_event_type   errEvent,
  input wire logic                     measResultValid,
  input wire logic [7:0]               esrEvents,
  input wire logic signed [15:0]       dispCode,
  input wire logic                     dispShowErr
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Clear-status write drops any event of the same cycle from queue and status bits; the display still takes it
  logic        cls;
  logic [23:0] ev;
  assign cls = busReq.wr && busReq.addr == eeq_pkg::REG_CLS;
  assign ev = errEvent;
  cmd_bit_a: assert property (
    ev inside {24'h40, 24'h20, 24'h10} && !cls |=> esrEvents[5])
    else $error("command bit missing");
  exec_bit_a: assert property (
    ev inside {24'h2, 24'hC} && !cls |=> esrEvents[4])
    else $error("execution bit missing");
  dev_bit_a: assert property (
    ev == 24'h1 && !cls |=> esrEvents[3])
    else $error("device bit missing");
  quiet_esr_a: assert property (
    ev[23:4] == 20'h0 && ev[1:0] == 2'h0 && ev[3:2] != 2'h3
    && !busReq.wr |=> $stable(esrEvents))
    else $error("status moved without event");
  cmd_only_a: assert property (
    ev == 24'h40 && !busReq.wr |=> $stable({esrEvents[4], esrEvents[2]}))
    else $error("command event set other class");
  rd_idle_a: assert property (
    !busReq.rd |=> busRdata == 32'h0)
    else $error("read data without read");
  disp_set_a: assert property (
    ev == 24'h40 && !cls |=> dispShowErr && dispCode == 16'hFF9A)
    else $error("display not showing error");
  disp_clr_a: assert property (
    measResultValid && ev == 24'h0 |=> !dispShowErr)
    else $error("display not released");
  cover property (ev == 24'h1);
  cover property (busReq.rd && busReq.addr == eeq_pkg::REG_ERRQ);
  cover property (measResultValid && dispShowErr);
endmodule : eeq_checker
bind error_event_queue eeq_checker u_chk (
  .mclk(mclk), .nrst(nrst), .busReq(busReq), .busRdata(busRdata),
  .errEvent(errEvent), .measResultValid(measResultValid),
  .esrEvents(esrEvents), .dispCode(dispCode), .dispShowErr(dispShowErr)
);
`default_nettype wire

/* eeq_host_model.sv */
// Host controller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module eeq_host_model (
  input  wire logic                     mclk,
  output var  eeq_pkg::eeq_bus_req_type busReq,
  input  wire logic [31:0]              busRdata
);
  // Bus idle from time zero; strobes last one cycle
  initial busReq = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge mclk);
    busReq <= '0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so take it at that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge mclk);
    busReq <= '0;
    @(posedge mclk);
    d = busRdata;
  endtask : rd
endmodule : eeq_host_model
`default_nettype wire

/* tb_error_event_queue.sv */
// Testbench of the error event queue
`timescale 1ns/1ps
`default_nettype none
module tb_error_event_queue;
  logic mclk, nrst, measResultValid, dispShowErr;
  eeq_pkg::eeq_bus_req_type busReq;
  eeq_pkg::eeq_event_type   errEvent;
  logic [31:0]              busRdata, rdat;
  logic [7:0]               esrEvents;
  logic signed [15:0]       dispCode;
  int                       failures, comparisons;
  string                    txt;
  // Event patterns, expected status bits and popped class/code per event
  logic [23:0] evTab [7] = '{24'h40, 24'h20, 24'h10, 24'hC, 24'h2, 24'h1,
                             {1'h1, 16'hFE66, 7'h0}};
  logic [7:0]  esrTab [7] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04};
  logic [18:0] popTab [7] = '{{3'h1, 16'hFF9A}, {3'h1, 16'hFF8F},
    {3'h1, 16'hFF97}, {3'h2, 16'hFF38}, {3'h2, 16'hFF38}, {3'h3, 16'hFEB6},
    {3'h4, 16'hFE66}};
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  error_event_queue DUT (.mclk(mclk), .nrst(nrst), .busReq(busReq),
    .busRdata(busRdata), .errEvent(errEvent),
    .measResultValid(measResultValid), .esrEvents(esrEvents),
    .dispCode(dispCode), .dispShowErr(dispShowErr));
  eeq_host_model H (.mclk(mclk), .busReq(busReq), .busRdata(busRdata));
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] a, logic [31:0] e);
    H.rd(a, rdat);
    chk(n, e, rdat);
  endtask : rchk
  // One-cycle event, then a quiet cycle
  task automatic fire(input logic [23:0] e);
    @(posedge mclk);
    errEvent <= e;
    @(posedge mclk);
    errEvent <= '0;
  endtask : fire
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    failures++;
    end_sim();
  end
  initial begin
    nrst = 1'h0;
    errEvent = '0;
    measResultValid = 1'h0;
    repeat (3) @(posedge mclk);
    nrst <= 1'h1;
    rchk("errq", eeq_pkg::REG_ERRQ, 32'h0);
    rchk("status", eeq_pkg::REG_STATUS, 32'h20);
    rchk("unmapped", 8'h20, 32'h0);
    // Range error before rounding is no event at all
    fire(24'h08);
    rchk("esr", eeq_pkg::REG_ESR, 32'h0);
    rchk("status", eeq_pkg::REG_STATUS, 32'h20);
    for (int i = 0; i < 7; i++) begin
      fire(evTab[i]);
      rchk("esr", eeq_pkg::REG_ESR, {24'h0, esrTab[i]});
      H.wr(eeq_pkg::REG_ESR, 32'hFF);
      rchk("errq", eeq_pkg::REG_ERRQ, {13'h0, popTab[i]});
    end
    fire(24'h40);
    rchk("disp", eeq_pkg::REG_DISP, 32'h0001FF9A);
    @(posedge mclk);
    measResultValid <= 1'h1;
    @(posedge mclk);
    measResultValid <= 1'h0;
    rchk("disp", eeq_pkg::REG_DISP, 32'h0000FF9A);
    rchk("errq", eeq_pkg::REG_ERRQ, 32'h0001FF9A);
    txt = "-102,\"C";
    for (int j = 0; j < 7; j++) begin
      rchk("resp", eeq_pkg::REG_RESP, {23'h0, 1'h1, txt[j]});
    end
    fire(24'h40);
    H.wr(eeq_pkg::REG_CLS, 32'h0);
    rchk("status", eeq_pkg::REG_STATUS, 32'h20);
    rchk("esr", eeq_pkg::REG_ESR, 32'h0);
    for (int k = 1; k <= 31; k++) begin
      fire({1'h1, 16'(k), 7'h0});
    end
    rchk("status", eeq_pkg::REG_STATUS, 32'h5E);
    rchk("esr", eeq_pkg::REG_ESR, 32'h08);
    for (int k = 1; k <= 29; k++) begin
      rchk("errq", eeq_pkg::REG_ERRQ, {13'h0, 3'h5, 16'(k)});
    end
    rchk("errq", eeq_pkg::REG_ERRQ, 32'h0006FEA2);
    rchk("errq", eeq_pkg::REG_ERRQ, 32'h0);
    // Empty query answers plus sign, zero and the no-error text
    txt = "+0,\"No error\"";
    for (int j = 0; j < 13; j++) begin
      rchk("resp", eeq_pkg::REG_RESP, {23'h0, 1'h1, txt[j]});
    end
    rchk("resp", eeq_pkg::REG_RESP, 32'h0);
    for (int k = 1; k <= 29; k++) begin
      fire({1'h1, 16'(k), 7'h0});
    end
    // Pop and push in one cycle with 29 errors queued must not overflow
    fork
      H.rd(eeq_pkg::REG_ERRQ, rdat);
      fire({1'h1, 16'h001E, 7'h0});
    join
    chk("errq", 32'h00050001, rdat);
    rchk("status", eeq_pkg::REG_STATUS, 32'h1D);
    // Mid-run reset empties the queue again
    @(posedge mclk);
    nrst <= 1'h0;
    @(posedge mclk);
    nrst <= 1'h1;
    rchk("status", eeq_pkg::REG_STATUS, 32'h20);
    end_sim();
  end
endmodule : tb_error_event_queue
`default_nettype wire
